// *** src/zxlp_core.sv ***
// Zero-crossing flags, timeouts, sequence check and line period
`timescale 1ns/10ps
`default_nettype none
module zxlp_core (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [zxlp_pkg::AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Sample domain inputs
  input wire logic sample_tick,
  input wire logic [6:0] cross_rise,
  input wire logic [6:0] cross_fall,
  input wire logic signed [3:0][zxlp_pkg::SW-1:0] lp_sample,
  // Consumers
  output logic cross_output_pin,
  output logic line_cycle_tick,
  output logic [6:0] angle_rise,
  output logic [31:0] resample_period,
  output logic irq
);
  import zxlp_pkg::*;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [11:0] status;
    logic [11:0] mask;
    logic [11:0] to_limit;
    logic [14:0] cfg;
    logic [31:0] user_per;
    logic [SW-1:0] thr;
    logic [2:0][11:0] to_cnt;
    logic [2:0] to_fired;
    logic [3:0][2:0] hold;
    logic [3:0][SW-1:0] prev_s;
    logic [3:0][7:0] ticks;
    logic [3:0][15:0] frac;
    logic [3:0] have_ref;
    logic [3:0][31:0] per;
    logic [3:0] seen;
    logic [7:0] seq_tmr;
    logic pin;
    logic lc_tick;
    logic [6:0] ang_rise;
    logic irq;
    logic [31:0] rs_per;
  } zxlp_state_t;

  zxlp_state_t s;
  zxlp_state_t next_s;

  // ********************************
  // Helpers
  // ********************************
  function automatic logic in_range(input logic [31:0] v);
    logic [32:0] p;
    p = {1'b0, v} + 33'h1;
    in_range = (p >= {1'b0, PER_MIN}) && (p <= {1'b0, PER_MAX});
  endfunction : in_range

  function automatic logic [SW-1:0] mag(input logic [SW-1:0] v);
    mag = v[SW-1] ? SW'(~v + 1'b1) : v;
  endfunction : mag

  logic [6:0] q_rise;
  logic [6:0] q_fall;
  logic [31:0] def_per;
  logic [31:0] pick;
  logic [SW+15:0] num;
  logic [SW+15:0] den;
  logic [SW+15:0] quo;
  logic [15:0] f;
  logic [7:0] tk;
  logic [31:0] p;
  logic [3:0] expct;
  logic [3:0] ev;
  logic [3:0] miss;
  logic [2:0] xs;
  logic wend;
  logic acc;
  logic wr_go;
  logic [11:0] clr;
  logic [11:0] set;

  always_comb begin
    next_s = s;
    def_per = s.cfg[CF_FREQ] ? DEF60 : DEF50;
    pick = 32'h0;
    num = '0;
    den = '0;
    quo = '0;
    f = 16'h0;
    tk = 8'h0;
    p = 32'h0;
    expct = 4'h0;
    ev = 4'h0;
    miss = 4'h0;
    wend = 1'b0;
    clr = 12'h0;
    set = 12'h0;
    xs = s.cfg[CF_XSRC+:3];
    q_rise = cross_rise & {7{sample_tick}};
    q_fall = cross_fall & {7{sample_tick}};
    for (int j = 0; j < 4; j++) begin
      if (mag(lp_sample[j]) < s.thr || s.hold[j] != 3'h0) begin
        q_rise[j+3] = 1'b0;
        q_fall[j+3] = 1'b0;
      end
    end
    // ********************************
    // APB slave
    // ********************************
    acc = psel && penable && !s.pready;
    wr_go = psel && penable && s.pready && pwrite;
    next_s.pready = acc;
    next_s.pslverr = 1'b0;
    if (acc && !pwrite) begin
      if (paddr == OFS_STATUS) begin
        next_s.prdata = {20'h0, s.status};
      end else if (paddr == OFS_MASK) begin
        next_s.prdata = {20'h0, s.mask};
      end else if (paddr == OFS_TOLIM) begin
        next_s.prdata = {20'h0, s.to_limit};
      end else if (paddr == OFS_CFG) begin
        next_s.prdata = {17'h0, s.cfg};
      end else if (paddr == OFS_UPER) begin
        next_s.prdata = s.user_per;
      end else if (paddr >= OFS_PER0 && paddr < OFS_RSPER
                   && paddr[1:0] == 2'b00) begin
        next_s.prdata = s.per[2'(paddr[AW-1:2] - OFS_PER0[AW-1:2])];
      end else if (paddr == OFS_RSPER) begin
        next_s.prdata = s.rs_per;
      end else if (paddr == OFS_THR) begin
        next_s.prdata = {{(32 - SW){1'b0}}, s.thr};
      end else begin
        next_s.prdata = 32'h0;
        next_s.pslverr = 1'b1;
      end
    end else if (acc) begin
      next_s.prdata = 32'h0;
      if (paddr != OFS_STATUS && paddr != OFS_MASK
          && paddr != OFS_TOLIM && paddr != OFS_CFG
          && paddr != OFS_UPER && paddr != OFS_THR) begin
        next_s.pslverr = 1'b1;
      end
    end
    if (wr_go) begin
      if (paddr == OFS_STATUS) begin
        clr = pwdata[11:0];
      end else if (paddr == OFS_MASK) begin
        next_s.mask = pwdata[11:0] & ST_MASK;
      end else if (paddr == OFS_TOLIM) begin
        next_s.to_limit = pwdata[11:0];
      end else if (paddr == OFS_CFG) begin
        next_s.cfg = pwdata[14:0] & CF_MASK;
      end else if (paddr == OFS_UPER) begin
        next_s.user_per = pwdata;
      end else if (paddr == OFS_THR) begin
        next_s.thr = pwdata[SW-1:0];
      end
    end
    // ********************************
    // Sample domain work
    // ********************************
    next_s.lc_tick = 1'b0;
    next_s.ang_rise = 7'h0;
    if (sample_tick) begin
      set[6:0] = q_rise | q_fall;
      next_s.ang_rise = q_rise;
      if (xs < 3'd7 && (q_rise[xs] || q_fall[xs])) begin
        next_s.lc_tick = 1'b1;
      end
      if (xs < 3'd7 && q_rise[xs]) begin
        next_s.pin = 1'b1;
      end else if (xs < 3'd7 && q_fall[xs]) begin
        next_s.pin = 1'b0;
      end
      for (int j = 0; j < 4; j++) begin
        if (q_rise[j+3] || q_fall[j+3]) begin
          next_s.hold[j] = HOLD_TICKS - 3'h1;
        end else if (s.hold[j] != 3'h0) begin
          next_s.hold[j] = s.hold[j] - 3'h1;
        end
        next_s.prev_s[j] = lp_sample[j];
        tk = (s.ticks[j] < MAX_TICKS) ? s.ticks[j] + 8'h1 : MAX_TICKS;
        if (q_rise[j+3]) begin
          if (s.prev_s[j][SW-1] && !lp_sample[j][SW-1]) begin
            num = {(SW+16)'(mag(s.prev_s[j])) << 16};
            den = (SW+16)'({1'b0, mag(s.prev_s[j])})
                + (SW+16)'({1'b0, lp_sample[j]});
            quo = num / den;
            f = quo[15:0];
          end else begin
            f = 16'h0;
          end
          // period scaled by 65536, minus one
          p = {8'h0, tk, 16'h0} + {16'h0, f}
            - {16'h0, s.frac[j]} - 32'h1;
          if (s.have_ref[j] && in_range(p)) begin
            next_s.per[j] = p;
          end else begin
            next_s.per[j] = def_per;
          end
          next_s.frac[j] = f;
          next_s.have_ref[j] = 1'b1;
          next_s.ticks[j] = 8'h0;
        end else begin
          next_s.ticks[j] = tk;
          if (tk >= MAX_TICKS) begin
            next_s.have_ref[j] = 1'b0;
            next_s.per[j] = def_per;
          end
        end
      end
      for (int k = 0; k < 3; k++) begin
        if (q_rise[k+3] || q_fall[k+3]) begin
          next_s.to_cnt[k] = 12'h0;
          next_s.to_fired[k] = 1'b0;
        end else if (s.to_limit != 12'h0 && !s.to_fired[k]) begin
          next_s.to_cnt[k] = s.to_cnt[k] + 12'h1;
          if (s.to_cnt[k] + 12'h1 == s.to_limit) begin
            set[ST_TO+k] = 1'b1;
            next_s.to_fired[k] = 1'b1;
          end
        end
      end
      if (s.cfg[CF_WIRE+:3] == WIRE_3A || s.cfg[CF_WIRE+:3] == WIRE_3B) begin
        expct = 4'hf;
        ev = {q_fall[5], q_rise[5], q_fall[3], q_rise[3]};
      end else begin
        expct = 4'h7;
        ev = {1'b0, q_rise[5], q_rise[4], q_rise[3]};
      end
      wend = q_rise[3] || s.seq_tmr >= MAX_TICKS;
      if (wend) begin
        miss = expct & ~(s.seen | ev);
        if (miss != 4'h0 && miss != expct) begin
          set[ST_SEQ] = 1'b1;
        end
        next_s.seen = 4'h0;
        next_s.seq_tmr = 8'h0;
      end else begin
        next_s.seen = (s.seen | ev) & expct;
        next_s.seq_tmr = s.seq_tmr + 8'h1;
      end
    end
    // Set wins over a clear in the same cycle
    next_s.status = ((s.status & ~clr) | set) & ST_MASK;
    if (s.cfg[CF_UPER]) begin
      pick = s.user_per;
    end else begin
      pick = s.per[s.cfg[CF_PSRC+:2]];
    end
    next_s.rs_per = in_range(pick) ? pick : def_per;
    next_s.irq = |(s.status & s.mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.per <= {4{DEF50}};
      s.rs_per <= DEF50;
      s.user_per <= DEF50;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign cross_output_pin = s.pin;
  assign line_cycle_tick = s.lc_tick;
  assign angle_rise = s.ang_rise;
  assign resample_period = s.rs_per;
  assign irq = s.irq;

  // ********************************
  // Assertions
  // ********************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  AST_CROSS_SET: assert property (
    sample_tick && (cross_rise[0] || cross_fall[0]) |=> s.status[0])
    else $error("crossing flag not set");
  AST_CROSS_STAY: assert property (
    !s.status[1] && !(sample_tick && (cross_rise[1] || cross_fall[1]))
    |=> !s.status[1])
    else $error("crossing flag set without crossing");
  AST_TO_AT_LIMIT: assert property (
    $rose(s.status[ST_TO]) && !$past(s.status[ST_TO])
    |-> $past(s.to_cnt[0]) + 12'h1 == $past(s.to_limit))
    else $error("timeout flag not at limit");
  AST_TO_RESTART: assert property (
    q_rise[3] |=> s.to_cnt[0] == 12'h0 && !s.to_fired[0])
    else $error("timeout counter not restarted");
  AST_IRQ: assert property (
    s.status[ST_TO] && s.mask[ST_TO] |=> irq)
    else $error("masked timeout gave no interrupt");
  AST_PIN_HOLD: assert property (
    $changed(cross_output_pin) |-> line_cycle_tick)
    else $error("pin moved without crossing");
  AST_PER_VALID: assert property (
    $changed(s.per[0]) |-> $past(sample_tick)
    && (in_range(s.per[0])
    || s.per[0] == ($past(s.cfg[CF_FREQ]) ? DEF60 : DEF50)))
    else $error("period outside range");
  AST_HOLDOFF: assert property (
    q_rise[4] |=> (!q_rise[4] && !q_fall[4]) [*3])
    else $error("crossing inside holdoff");
  AST_USER_PER: assert property (
    s.cfg[CF_UPER] && in_range(s.user_per) && $stable(s.user_per)
    |=> resample_period == $past(s.user_per))
    else $error("user period not used");
  AST_ANGLE: assert property (
    sample_tick && cross_fall[0] && !cross_rise[0] |=> !angle_rise[0])
    else $error("angle strobe on falling edge");
endmodule : zxlp_core
`default_nettype wire

// *** src/zxlp_pkg.sv ***
// Constants for the zero-crossing timing block
package zxlp_pkg;
  // ********************************
  // Widths
  // ********************************
  localparam int SW = 24;
  localparam int AW = 8;
  // ********************************
  // Register byte offsets
  // ********************************
  localparam logic [AW-1:0] OFS_STATUS = 8'h00;
  localparam logic [AW-1:0] OFS_MASK = 8'h04;
  localparam logic [AW-1:0] OFS_TOLIM = 8'h08;
  localparam logic [AW-1:0] OFS_CFG = 8'h0c;
  localparam logic [AW-1:0] OFS_UPER = 8'h10;
  localparam logic [AW-1:0] OFS_PER0 = 8'h14;
  localparam logic [AW-1:0] OFS_RSPER = 8'h24;
  localparam logic [AW-1:0] OFS_THR = 8'h28;
  // ********************************
  // Field positions
  // ********************************
  localparam int ST_TO = 8;
  localparam int ST_SEQ = 11;
  localparam int CF_FREQ = 0;
  localparam int CF_UPER = 1;
  localparam int CF_XSRC = 4;
  localparam int CF_PSRC = 8;
  localparam int CF_WIRE = 12;
  localparam logic [11:0] ST_MASK = 12'hfff;
  localparam logic [14:0] CF_MASK = 15'h7373;
  // ********************************
  // Period scaling and defaults
  // ********************************
  localparam logic [31:0] DEF50 = 32'h0050_0000;
  localparam logic [31:0] DEF60 = 32'h0042_aaaa;
  // 70 Hz and 40 Hz as (period+1) counts
  localparam logic [31:0] PER_MIN = 32'h0039_2600;
  localparam logic [31:0] PER_MAX = 32'h0064_0000;
  localparam int SAMPLE_HZ = 4000;
  localparam int MIN_HZ = 40;
  localparam logic [7:0] MAX_TICKS = 8'(SAMPLE_HZ / MIN_HZ + 1);
  // ********************************
  // Crossing holdoff and wiring modes
  // ********************************
  localparam int HOLD_NS = 1000000;
  localparam int SAMPLE_NS = 250000;
  localparam logic [2:0] HOLD_TICKS =
    3'((HOLD_NS + SAMPLE_NS - 1) / SAMPLE_NS);
  localparam logic [2:0] WIRE_4W = 3'h0;
  localparam logic [2:0] WIRE_3A = 3'h1;
  localparam logic [2:0] WIRE_3B = 3'h4;
endpackage : zxlp_pkg

// *** verification/zxlp_core_tb_top.sv ***
// Self-checking testbench for the zero-crossing timing block
`timescale 1ns/10ps
`default_nettype none
module zxlp_core_tb_top;
  import zxlp_pkg::*;
  // ********************************
  // Signals
  // ********************************
  logic pclk, presetn, psel, penable, pwrite, sample_tick;
  logic [AW-1:0] paddr;
  logic [31:0] pwdata, prdata, resample_period, q;
  logic pready, pslverr, cross_output_pin, line_cycle_tick, irq, e;
  logic [6:0] cross_rise, cross_fall, angle_rise;
  logic signed [3:0][SW-1:0] lp_sample;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  zxlp_core dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample_tick(sample_tick),
    .cross_rise(cross_rise), .cross_fall(cross_fall),
    .lp_sample(lp_sample), .cross_output_pin(cross_output_pin),
    .line_cycle_tick(line_cycle_tick), .angle_rise(angle_rise),
    .resample_period(resample_period), .irq(irq)
  );
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Run is under 2000 cycles; ceiling leaves wide margin
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      $display("FAIL at %0t: run timed out", $time);
      results();
    end
  end
  // ********************************
  // Tasks
  // ********************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic x);
    apb(1'b1, a, d);
    chk({31'h0, e}, {31'h0, x});
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    chk(q & m, x);
  endtask : rd
  // Pulse outputs are read at the edge after the tick edge
  task automatic tick(input logic [6:0] r, input logic [6:0] f,
                      input logic signed [SW-1:0] s);
    sample_tick <= 1'b1;
    cross_rise <= r;
    cross_fall <= f;
    lp_sample[0] <= s;
    @(posedge pclk);
    sample_tick <= 1'b0;
    cross_rise <= 7'h00;
    cross_fall <= 7'h00;
    @(posedge pclk);
  endtask : tick
  task automatic idle(input int n);
    repeat (n) tick(7'h00, 7'h00, 24'sh000100);
  endtask : idle
  task automatic results();
    $display("Counts: %0d compares, %0d errors", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : results
  // ********************************
  // Tests
  // ********************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sample_tick = 1'b0;
    cross_rise = 7'h00;
    cross_fall = 7'h00;
    lp_sample = {4{24'h000100}};
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(OFS_PER0, DEF50, 32'hffff_ffff);
    rd(OFS_RSPER, DEF50, 32'hffff_ffff);
    rd(OFS_UPER, DEF50, 32'hffff_ffff);
    wr(OFS_PER0, 32'h1, 1'b1);
    rd(8'h40, 32'h0, 32'hffff_ffff);
    chk({31'h0, e}, 32'h1);
    $display("test reset_and_map done");
    tick(7'h02, 7'h01, 24'sh000100);
    rd(OFS_STATUS, 32'h3, 32'h3);
    wr(OFS_STATUS, 32'h3, 1'b0);
    idle(3);
    rd(OFS_STATUS, 32'h0, 32'h7f);
    $display("test flags done");
    wr(OFS_CFG, 32'h30, 1'b0);
    tick(7'h08, 7'h00, 24'sh000100);
    chk({23'h0, cross_output_pin, line_cycle_tick, angle_rise},
        32'h188);
    idle(3);
    tick(7'h00, 7'h08, 24'sh000100);
    chk({23'h0, cross_output_pin, line_cycle_tick, angle_rise},
        32'h080);
    // Rise one tick after the fall falls inside the holdoff
    tick(7'h09, 7'h00, 24'sh000100);
    chk({23'h0, cross_output_pin, line_cycle_tick, angle_rise},
        32'h001);
    $display("test pin done");
    wr(OFS_TOLIM, 32'h5, 1'b0);
    rd(OFS_TOLIM, 32'h5, 32'hffff_ffff);
    wr(OFS_MASK, 32'h100, 1'b0);
    idle(3);
    tick(7'h08, 7'h00, 24'sh000100);
    idle(4);
    rd(OFS_STATUS, 32'h0, 32'h100);
    idle(1);
    rd(OFS_STATUS, 32'h100, 32'h100);
    chk({31'h0, irq}, 32'h1);
    wr(OFS_STATUS, 32'h100, 1'b0);
    idle(3);
    rd(OFS_STATUS, 32'h0, 32'h100);
    chk({31'h0, irq}, 32'h0);
    $display("test timeout done");
    wr(OFS_CFG, 32'h0, 1'b0);
    tick(7'h00, 7'h00, -24'sd1);
    tick(7'h08, 7'h00, 24'sd1);
    idle(78);
    tick(7'h00, 7'h00, -24'sd3);
    tick(7'h08, 7'h00, 24'sd1);
    rd(OFS_PER0, 32'h0050_3fff, 32'hffff_ffff);
    chk(resample_period, 32'h0050_3fff);
    $display("test period done");
    wr(OFS_UPER, 32'h0063_ffff, 1'b0);
    wr(OFS_CFG, 32'h3, 1'b0);
    rd(OFS_RSPER, 32'h0063_ffff, 32'hffff_ffff);
    wr(OFS_UPER, 32'h0064_0000, 1'b0);
    rd(OFS_RSPER, DEF60, 32'hffff_ffff);
    wr(OFS_CFG, 32'h1, 1'b0);
    rd(OFS_RSPER, 32'h0050_3fff, 32'hffff_ffff);
    $display("test resample done");
    wr(OFS_STATUS, 32'hfff, 1'b0);
    idle(102);
    rd(OFS_PER0, DEF60, 32'hffff_ffff);
    rd(OFS_STATUS, 32'h0, 32'h800);
    tick(7'h08, 7'h00, 24'sh000100);
    idle(4);
    tick(7'h10, 7'h00, 24'sh000100);
    idle(4);
    tick(7'h08, 7'h00, 24'sh000100);
    rd(OFS_STATUS, 32'h800, 32'h800);
    $display("test sequence done");
    wr(OFS_THR, 32'h200, 1'b0);
    idle(4);
    tick(7'h08, 7'h00, 24'sh000100);
    chk({25'h0, angle_rise}, 32'h0);
    $display("test threshold done");
    // Three-wire: both edges of A and C expected per window
    wr(OFS_THR, 32'h0, 1'b0);
    wr(OFS_CFG, 32'h1000, 1'b0);
    wr(OFS_STATUS, 32'h800, 1'b0);
    tick(7'h00, 7'h08, 24'sh000100);
    idle(3);
    tick(7'h20, 7'h00, 24'sh000100);
    idle(3);
    tick(7'h00, 7'h20, 24'sh000100);
    idle(3);
    tick(7'h08, 7'h00, 24'sh000100);
    rd(OFS_STATUS, 32'h0, 32'h800);
    idle(3);
    tick(7'h20, 7'h00, 24'sh000100);
    idle(3);
    tick(7'h08, 7'h00, 24'sh000100);
    rd(OFS_STATUS, 32'h800, 32'h800);
    $display("test three_wire done");
    results();
  end
endmodule : zxlp_core_tb_top
`default_nettype wire
